/* File: inc/tsr_pkg.sv */
package tsr_pkg;

    // ****************************************
    // serial port framing
    // ****************************************
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int FRAME_BITS = 16;
    localparam logic [3:0] LAST_HDR_BIT = 4'h7;
    localparam logic [3:0] LAST_FRAME_BIT = 4'hf;
    localparam logic RW_READ = 1'b0;
    localparam int SYNC_STAGES = 3;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [6:0] ADDR_MAIN_STATUS = 7'h40;
    localparam logic [6:0] ADDR_SUBUNIT_INIT = 7'h41;
    localparam logic [6:0] ADDR_SIGNAL_STRENGTH = 7'h42;
    localparam logic [6:0] ADDR_AVG_FREQ_DEV = 7'h43;
    localparam logic [6:0] ADDR_INST_FREQ_DEV = 7'h44;
    localparam logic [6:0] ADDR_CAL_PUMP = 7'h45;
    localparam logic [6:0] ADDR_REV_OSC_ARRAY = 7'h46;
    localparam logic [6:0] ADDR_OSC_CAL = 7'h47;
    localparam logic [6:0] ADDR_CONV_SAMPLE = 7'h48;
    localparam logic [6:0] ADDR_CHANFILT_I_UPPER = 7'h49;

    // ****************************************
    // main status field positions
    // ****************************************
    localparam int ST_CAL_DONE = 7;
    localparam int ST_LOCK_FAIL = 6;
    localparam int ST_LOCK_NOW = 5;
    localparam int ST_LOCK_FILT = 4;
    localparam int ST_CARRIER = 3;
    localparam int ST_LOCK_PIN = 2;
    localparam int ST_DATA_CLK_PIN = 1;
    localparam int ST_DATA_IO_PIN = 0;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam logic [7:0] SHIFT_RST = 8'h00;
    localparam logic [6:0] ADDR_RST = 7'h00;
    localparam logic [3:0] CNT_RST = 4'h0;

    // serial engine states
    typedef enum logic [3:0] {
        TSR_IDLE = 4'b0001,
        TSR_HDR = 4'b0010,
        TSR_DATA = 4'b0100,
        TSR_DONE = 4'b1000
    } tsr_ser_e;

endpackage : tsr_pkg

/* File: rtl/tsr_pin_sync.sv */
`timescale 1ns/1ns
`default_nettype none

module tsr_pin_sync #(
    parameter int WIDTH = 6
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
    } tsr_sync_s;

    tsr_sync_s cur_ff;
    tsr_sync_s nxt_cur;

    // ****************************************
    // three-stage capture, accept on agreement
    // ****************************************
    // only s2 reads s1; the level moves once s2 and s3 agree
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.s1 = pin_in;
        nxt_cur.s2 = cur_ff.s1;
        nxt_cur.s3 = cur_ff.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (cur_ff.s2[i] == cur_ff.s3[i]) begin
                nxt_cur.lvl[i] = cur_ff.s3[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign pin_out = cur_ff.lvl;

endmodule : tsr_pin_sync

`default_nettype wire

/* File: rtl/tsr_cal_tracker.sv */
`timescale 1ns/1ns
`default_nettype none

module tsr_cal_tracker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cal_start,
    input wire logic cal_finish,
    input wire logic powerup_lock_fail_evt,
    output logic cal_done,
    output logic powerup_lock_fail
);

    typedef struct packed {
        logic cal_done;
        logic lock_fail;
    } tsr_cal_s;

    tsr_cal_s cur_ff;
    tsr_cal_s nxt_cur;

    // ****************************************
    // calibration and sequencing flags
    // ****************************************
    // finish beats start in the same cycle so a completed run is never hidden
    always_comb begin
        nxt_cur = cur_ff;
        if (cal_start) begin
            nxt_cur.cal_done = 1'b0;
        end
        if (cal_finish) begin
            nxt_cur.cal_done = 1'b1;
        end
        // sticky until reset; no read or write clears it
        if (powerup_lock_fail_evt) begin
            nxt_cur.lock_fail = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign cal_done = cur_ff.cal_done;
    assign powerup_lock_fail = cur_ff.lock_fail;

endmodule : tsr_cal_tracker

`default_nettype wire

/* File: rtl/tsr_status_bank.sv */
// Behaviour
// - cal-done clears on start, sets on finish
// - power-up lock failure sets sequencing error
// - status bit 5 shows raw lock
// - status bit 4 shows qualified lock
// - carrier sense when strength above threshold
// - bits 2..0 mirror lock, clock, data pins
// - eight subunit init-complete flags at 41h
// - 7-bit strength, bit 7 reads zero
// - average deviation equals signed decision level
// - instantaneous offset signed at 44h, over 8
// - cal converter and pump codes at 45h
// - revision code and oscillator array at 46h
// - comparators and cal current at 47h
// - mixer and converter samples at 48h
// - channel filter in-phase upper bits at 49h
// - status and init registers read-only
`timescale 1ns/1ns
`default_nettype none

module tsr_status_bank #(
    // value is arbitrary, set per silicon spin
    parameter logic [2:0] SILICON_REV = 3'h5
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cfg_sel_n,
    input wire logic cfg_clk,
    input wire logic cfg_din,
    output logic cfg_dout,
    input wire logic lock_pin,
    input wire logic data_clock_pin,
    input wire logic data_io_pin,
    input wire logic cal_start,
    input wire logic cal_finish,
    input wire logic powerup_lock_fail_evt,
    input wire logic pll_lock_now,
    input wire logic pll_lock_filtered,
    input wire logic [6:0] carrier_level,
    input wire logic [6:0] signal_strength_value,
    input wire logic adc_init_flag,
    input wire logic gainctl_init_flag,
    input wire logic shaping_filter_init_flag,
    input wire logic offset_logic_init_flag,
    input wire logic modem_sync_init_flag,
    input wire logic synth_digital_init_flag,
    input wire logic sequencer_init_flag,
    input wire logic cal_lock_init_flag,
    input wire logic [7:0] decision_level,
    input wire logic [7:0] inst_offset,
    input wire logic [3:0] cal_dac_code,
    input wire logic [3:0] pump_current_code,
    input wire logic [4:0] osc_cap_array_code,
    input wire logic freq_cmp_out,
    input wire logic osc_current_cmp,
    input wire logic [5:0] osc_cal_current_code,
    input wire logic [1:0] adc_mix_sample,
    input wire logic [2:0] adc_i_sample,
    input wire logic [2:0] adc_q_sample,
    input wire logic [7:0] chanfilt_i_upper
);

    // ****************************************
    // engine state
    // ****************************************
    typedef struct packed {
        tsr_pkg::tsr_ser_e state;
        logic clk_q;
        logic [3:0] bit_cnt;
        logic [6:0] addr;
        logic [7:0] shift;
        logic dout;
    } tsr_bank_s;

    tsr_bank_s cur_ff;
    tsr_bank_s nxt_cur;

    logic [5:0] pins_sync;
    logic sel_n_s;
    logic sclk_s;
    logic din_s;
    logic lock_pin_s;
    logic data_clock_pin_s;
    logic data_io_pin_s;
    logic cal_done;
    logic powerup_lock_fail;
    logic carrier_sense;
    logic [7:0] main_status;
    logic [7:0] subunit_init_flags;
    logic [7:0] rd_data;
    logic sclk_rise;

    // ****************************************
    // pin capture
    // ****************************************
    // serial port and mirrored pins come from outside this clock
    tsr_pin_sync #(
        .WIDTH(6)
    ) u_pin_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .pin_in({cfg_sel_n, cfg_clk, cfg_din, lock_pin, data_clock_pin, data_io_pin}),
        .pin_out(pins_sync)
    );

    // unpack synchronised levels
    assign sel_n_s = pins_sync[5];
    assign sclk_s = pins_sync[4];
    assign din_s = pins_sync[3];
    assign lock_pin_s = pins_sync[2];
    assign data_clock_pin_s = pins_sync[1];
    assign data_io_pin_s = pins_sync[0];

    // ****************************************
    // calibration and sequencing flags
    // ****************************************
    tsr_cal_tracker u_cal_tracker (
        .clk(clk),
        .sys_rst(sys_rst),
        .cal_start(cal_start),
        .cal_finish(cal_finish),
        .powerup_lock_fail_evt(powerup_lock_fail_evt),
        .cal_done(cal_done),
        .powerup_lock_fail(powerup_lock_fail)
    );

    // ****************************************
    // live status words
    // ****************************************
    // strictly above: equal to the threshold is not a carrier
    assign carrier_sense = (signal_strength_value > carrier_level);

    // status word assembled from live sources, nothing held here
    always_comb begin
        main_status = tsr_pkg::READ_ZERO;
        main_status[tsr_pkg::ST_CAL_DONE] = cal_done;
        main_status[tsr_pkg::ST_LOCK_FAIL] = powerup_lock_fail;
        main_status[tsr_pkg::ST_LOCK_NOW] = pll_lock_now;
        main_status[tsr_pkg::ST_LOCK_FILT] = pll_lock_filtered;
        main_status[tsr_pkg::ST_CARRIER] = carrier_sense;
        main_status[tsr_pkg::ST_LOCK_PIN] = lock_pin_s;
        main_status[tsr_pkg::ST_DATA_CLK_PIN] = data_clock_pin_s;
        main_status[tsr_pkg::ST_DATA_IO_PIN] = data_io_pin_s;
    end

    // init-complete flags, converter control in the top bit
    assign subunit_init_flags = {
        adc_init_flag,
        gainctl_init_flag,
        shaping_filter_init_flag,
        offset_logic_init_flag,
        modem_sync_init_flag,
        synth_digital_init_flag,
        sequencer_init_flag,
        cal_lock_init_flag
    };

    // ****************************************
    // read decode
    // ****************************************
    // unmapped addresses answer zero so a stray read is harmless
    always_comb begin
        rd_data = tsr_pkg::READ_ZERO;
        unique case (cur_ff.addr)
            tsr_pkg::ADDR_MAIN_STATUS: begin
                rd_data = main_status;
            end
            tsr_pkg::ADDR_SUBUNIT_INIT: begin
                rd_data = subunit_init_flags;
            end
            tsr_pkg::ADDR_SIGNAL_STRENGTH: begin
                rd_data = {1'b0, signal_strength_value};
            end
            tsr_pkg::ADDR_AVG_FREQ_DEV: begin
                rd_data = decision_level;
            end
            tsr_pkg::ADDR_INST_FREQ_DEV: begin
                rd_data = inst_offset;
            end
            tsr_pkg::ADDR_CAL_PUMP: begin
                rd_data = {cal_dac_code, pump_current_code};
            end
            tsr_pkg::ADDR_REV_OSC_ARRAY: begin
                rd_data = {SILICON_REV, osc_cap_array_code};
            end
            tsr_pkg::ADDR_OSC_CAL: begin
                rd_data = {freq_cmp_out, osc_current_cmp, osc_cal_current_code};
            end
            tsr_pkg::ADDR_CONV_SAMPLE: begin
                rd_data = {adc_mix_sample, adc_i_sample, adc_q_sample};
            end
            tsr_pkg::ADDR_CHANFILT_I_UPPER: begin
                rd_data = chanfilt_i_upper;
            end
            default: begin
                rd_data = tsr_pkg::READ_ZERO;
            end
        endcase
    end

    // ****************************************
    // serial engine
    // ****************************************
    // edge seen on the synchronised clock, a few cycles behind the pin
    assign sclk_rise = sclk_s & ~cur_ff.clk_q;

    // header is seven address bits then the direction bit, msb first;
    // the output bit moves just after each rising edge, so the host
    // samples the previous bit on that edge before it changes
    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.clk_q = sclk_s;
        if (sel_n_s) begin
            // deselect ends any frame wherever it stands
            nxt_cur.state = tsr_pkg::TSR_IDLE;
            nxt_cur.bit_cnt = tsr_pkg::CNT_RST;
            nxt_cur.dout = 1'b0;
        end else begin
            unique case (cur_ff.state)
                tsr_pkg::TSR_IDLE: begin
                    nxt_cur.state = tsr_pkg::TSR_HDR;
                    nxt_cur.bit_cnt = tsr_pkg::CNT_RST;
                end
                tsr_pkg::TSR_HDR: begin
                    if (sclk_rise) begin
                        nxt_cur.bit_cnt = cur_ff.bit_cnt + 4'h1;
                        if (cur_ff.bit_cnt == tsr_pkg::LAST_HDR_BIT) begin
                            nxt_cur.state = tsr_pkg::TSR_DATA;
                            if (din_s == tsr_pkg::RW_READ) begin
                                // snapshot taken now: value at the moment of the read
                                nxt_cur.dout = rd_data[7];
                                nxt_cur.shift = {rd_data[6:0], 1'b0};
                            end else begin
                                // write frame: data clocked past and dropped
                                nxt_cur.dout = 1'b0;
                                nxt_cur.shift = tsr_pkg::SHIFT_RST;
                            end
                        end else begin
                            nxt_cur.addr = {cur_ff.addr[5:0], din_s};
                        end
                    end
                end
                tsr_pkg::TSR_DATA: begin
                    if (sclk_rise) begin
                        nxt_cur.bit_cnt = cur_ff.bit_cnt + 4'h1;
                        if (cur_ff.bit_cnt == tsr_pkg::LAST_FRAME_BIT) begin
                            nxt_cur.state = tsr_pkg::TSR_DONE;
                            nxt_cur.dout = 1'b0;
                        end else begin
                            nxt_cur.dout = cur_ff.shift[7];
                            nxt_cur.shift = {cur_ff.shift[6:0], 1'b0};
                        end
                    end
                end
                tsr_pkg::TSR_DONE: begin
                    // extra clocks before deselect are ignored
                    nxt_cur.dout = 1'b0;
                end
                default: begin
                    nxt_cur.state = tsr_pkg::TSR_IDLE;
                end
            endcase
        end
    end

    // single register for the whole engine
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cur_ff.state <= tsr_pkg::TSR_IDLE;
            cur_ff.clk_q <= 1'b0;
            cur_ff.bit_cnt <= tsr_pkg::CNT_RST;
            cur_ff.addr <= tsr_pkg::ADDR_RST;
            cur_ff.shift <= tsr_pkg::SHIFT_RST;
            cur_ff.dout <= 1'b0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // serial output straight from its flop
    assign cfg_dout = cur_ff.dout;

endmodule : tsr_status_bank

`default_nettype wire

/* File: sim/tsr_status_monitor.sv */
`timescale 1ns/1ns
`default_nettype none

module tsr_status_monitor #(
    // value is arbitrary
    parameter logic [2:0] SILICON_REV = 3'h5
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cfg_sel_n,
    input wire logic cfg_clk,
    input wire logic cfg_din,
    input wire logic cfg_dout,
    input wire logic lock_pin,
    input wire logic data_clock_pin,
    input wire logic data_io_pin,
    input wire logic cal_start,
    input wire logic cal_finish,
    input wire logic powerup_lock_fail_evt,
    input wire logic pll_lock_now,
    input wire logic pll_lock_filtered,
    input wire logic [6:0] carrier_level,
    input wire logic [6:0] signal_strength_value,
    input wire logic adc_init_flag,
    input wire logic gainctl_init_flag,
    input wire logic shaping_filter_init_flag,
    input wire logic offset_logic_init_flag,
    input wire logic modem_sync_init_flag,
    input wire logic synth_digital_init_flag,
    input wire logic sequencer_init_flag,
    input wire logic cal_lock_init_flag,
    input wire logic [7:0] decision_level,
    input wire logic [7:0] inst_offset,
    input wire logic [3:0] cal_dac_code,
    input wire logic [3:0] pump_current_code,
    input wire logic [4:0] osc_cap_array_code,
    input wire logic freq_cmp_out,
    input wire logic osc_current_cmp,
    input wire logic [5:0] osc_cal_current_code,
    input wire logic [1:0] adc_mix_sample,
    input wire logic [2:0] adc_i_sample,
    input wire logic [2:0] adc_q_sample,
    input wire logic [7:0] chanfilt_i_upper
);
    // ****************************************
    // frame tracking on the raw pins
    // ****************************************
    logic clk_q, cal_q, fail_q, rd, st_rd, hit;
    logic [4:0] cnt;
    logic [7:0] hdr, st, ro;
    logic [2:0] bi;

    // raw rises are seen before the design's synchroniser, so dout still holds the old bit
    always_ff @(posedge clk) begin
        clk_q <= cfg_clk;
        cal_q <= sys_rst ? 1'b0 : (cal_finish ? 1'b1 : (cal_start ? 1'b0 : cal_q));
        fail_q <= !sys_rst && (fail_q || powerup_lock_fail_evt);
        if (sys_rst || cfg_sel_n) begin
            cnt <= 5'h0;
            hdr <= 8'h00;
        end else if (cfg_clk && !clk_q && cnt < 5'd16) begin
            cnt <= cnt + 5'd1;
            hdr <= (cnt < 5'd8) ? {hdr[6:0], cfg_din} : hdr;
        end
    end

    // expected bytes from the live inputs
    always_comb begin
        rd = !hdr[0];
        st_rd = rd && hdr[7:1] == 7'h40;
        hit = cfg_clk && !clk_q && !cfg_sel_n && cnt >= 5'd8 && cnt < 5'd16;
        bi = 3'd7 - cnt[2:0];
        st = {cal_q, fail_q, pll_lock_now, pll_lock_filtered, signal_strength_value > carrier_level,
            lock_pin, data_clock_pin, data_io_pin};
        case (hdr[7:1])
            7'h41: ro = {adc_init_flag, gainctl_init_flag, shaping_filter_init_flag,
                offset_logic_init_flag, modem_sync_init_flag, synth_digital_init_flag,
                sequencer_init_flag, cal_lock_init_flag};
            7'h42: ro = {1'b0, signal_strength_value};
            7'h43: ro = decision_level;
            7'h44: ro = inst_offset;
            7'h45: ro = {cal_dac_code, pump_current_code};
            7'h46: ro = {SILICON_REV, osc_cap_array_code};
            7'h47: ro = {freq_cmp_out, osc_current_cmp, osc_cal_current_code};
            7'h48: ro = {adc_mix_sample, adc_i_sample, adc_q_sample};
            7'h49: ro = chanfilt_i_upper;
            default: ro = 8'h00;
        endcase
    end

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    cal_done_bit_a: assert property (hit && st_rd && bi == 3'd7 |-> cfg_dout == cal_q)
        else $error("cal done bit wrong");
    lock_fail_bit_a: assert property (hit && st_rd && bi == 3'd6 |-> cfg_dout == fail_q)
        else $error("lock fail bit wrong");
    lock_now_a: assert property (hit && st_rd && bi == 3'd5 |-> cfg_dout == st[5])
        else $error("raw lock bit wrong");
    lock_filt_a: assert property (hit && st_rd && bi == 3'd4 |-> cfg_dout == st[4])
        else $error("filtered lock bit wrong");
    carrier_bit_a: assert property (hit && st_rd && bi == 3'd3 |-> cfg_dout == st[3])
        else $error("carrier bit wrong");
    pin_mirror_a: assert property (hit && st_rd && bi < 3'd3 |-> cfg_dout == st[bi])
        else $error("pin mirror bit wrong");
    readout_bits_a: assert property (hit && rd && !st_rd |-> cfg_dout == ro[bi])
        else $error("readout bit wrong");
    write_quiet_a: assert property (hit && !rd |-> !cfg_dout)
        else $error("data out during write");
    // a mid-frame deselect needs the synchroniser delay plus one cycle to clear dout
    idle_low_a: assert property (cfg_sel_n [*6] |-> !cfg_dout)
        else $error("data out while deselected");

    cover property (hit && st_rd && bi == 3'd7 && cal_q);
    cover property (hit && st_rd && bi == 3'd6 && fail_q);
    cover property (hit && !rd);
endmodule : tsr_status_monitor

bind tsr_status_bank tsr_status_monitor #(.SILICON_REV(SILICON_REV)) mon_u (.*);

`default_nettype wire

/* File: sim/transceiver_status_readout_tb.sv */
`timescale 1ns/1ns
`default_nettype none

`define CHECK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin mismatches++; \
    $display("ERROR %0t: got %h exp %h", $time, got, exp); end end

module transceiver_status_readout_tb;
    // value is arbitrary
    localparam logic [2:0] REV = 3'h6;
    logic clk, sys_rst, sel_n, sck, sdi, sdo, cs, cf, ev, ln, lf, lp, dk, dat;
    logic exp_cal, exp_fail;
    logic [6:0] cl, rs;
    logic [63:0] r;
    logic [7:0] d;
    int mismatches, cmp_count;

    tsr_status_bank #(.SILICON_REV(REV)) dut_u (
        .clk(clk), .sys_rst(sys_rst), .cfg_sel_n(sel_n), .cfg_clk(sck), .cfg_din(sdi),
        .cfg_dout(sdo), .lock_pin(lp), .data_clock_pin(dk), .data_io_pin(dat),
        .cal_start(cs), .cal_finish(cf), .powerup_lock_fail_evt(ev), .pll_lock_now(ln),
        .pll_lock_filtered(lf), .carrier_level(cl), .signal_strength_value(rs), .adc_init_flag(r[7]),
        .gainctl_init_flag(r[6]), .shaping_filter_init_flag(r[5]),
        .offset_logic_init_flag(r[4]), .modem_sync_init_flag(r[3]),
        .synth_digital_init_flag(r[2]), .sequencer_init_flag(r[1]),
        .cal_lock_init_flag(r[0]), .decision_level(r[15:8]), .inst_offset(r[23:16]),
        .cal_dac_code(r[31:28]), .pump_current_code(r[27:24]), .osc_cap_array_code(r[36:32]),
        .freq_cmp_out(r[47]), .osc_current_cmp(r[46]), .osc_cal_current_code(r[45:40]),
        .adc_mix_sample(r[55:54]), .adc_i_sample(r[53:51]), .adc_q_sample(r[50:48]),
        .chanfilt_i_upper(r[63:56])
    );

    // ****************************************
    // serial host tasks
    // ****************************************
    always #50 clk = ~clk;

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // slow serial clock: 8 cycles each phase, well above the synchroniser delay
    task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] wd,
        output logic [7:0] q);
        logic [15:0] f;
        f = {a, w, wd};
        sel_n = 1'b0;
        tick(6);
        for (int i = 15; i >= 0; i--) begin
            sdi = f[i];
            tick(8);
            if (i < 8) q[i] = sdo;
            sck = 1'b1;
            tick(8);
            sck = 1'b0;
        end
        tick(8);
        sel_n = 1'b1;
        tick(8);
    endtask : xfer

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] q;
        xfer(a, 1'b0, 8'h00, q);
        `CHECK(q, e)
    endtask : rd

    task automatic pulse(input logic [2:0] m);
        {ev, cf, cs} = m;
        tick(1);
        {ev, cf, cs} = 3'h0;
        tick(2);
    endtask : pulse

    function automatic logic [7:0] exp_st();
        return {exp_cal, exp_fail, ln, lf, rs > cl, lp, dk, dat};
    endfunction : exp_st

    function automatic logic [7:0] exp_ro(input logic [6:0] a);
        case (a)
            7'h41: return r[7:0];
            7'h42: return {1'b0, rs};
            7'h46: return {REV, r[36:32]};
            7'h43, 7'h44, 7'h45, 7'h47, 7'h48, 7'h49: return r[8*(int'(a)-66) +: 8];
            default: return 8'h00;
        endcase
    endfunction : exp_ro

    task automatic test_done();
        if (mismatches == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    // watchdog: roughly five times the expected run length
    initial begin
        #5_000_000;
        mismatches++;
        test_done();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        clk = 0; sys_rst = 1; sel_n = 1; sck = 0; sdi = 0;
        {cs, cf, ev, ln, lf, lp, dk, dat} = 8'h00;
        cl = 7'h00; rs = 7'h00; r = 64'h0000_0000_0000_0000;
        exp_cal = 0; exp_fail = 0; mismatches = 0; cmp_count = 0;
        tick(8);
        sys_rst = 0;
        tick(8);
        rd(7'h40, exp_st());
        for (int p = 0; p < 2; p++) begin
            r = p ? 64'h5ac3_0f96_e71b_2d48 : 64'ha53c_f069_18e4_d2b7;
            rs = p ? 7'h7f : 7'h15;
            // host reads raw words; scaling to dB and hertz is left to its software
            for (int a = 'h41; a <= 'h44; a++) begin
                rd(7'(a), exp_ro(7'(a)));
            end
            for (int a = 'h45; a <= 'h49; a++) begin
                rd(7'(a), exp_ro(7'(a)));
            end
        end
        for (int p = 0; p < 2; p++) begin
            {ln, lf, lp, dk, dat} = p ? 5'b01010 : 5'b10101;
            rd(7'h40, exp_st());
        end
        cl = 7'h40;
        for (int p = 0; p < 2; p++) begin
            rs = 7'h40 + 7'(p);
            rd(7'h40, exp_st());
        end
        // finish only, start only, then both in one cycle
        for (int p = 0; p < 3; p++) begin
            pulse(p == 0 ? 3'b010 : (p == 1 ? 3'b001 : 3'b011));
            exp_cal = (p != 1);
            rd(7'h40, exp_st());
        end
        pulse(3'b100);
        exp_fail = 1;
        rd(7'h40, exp_st());
        rd(7'h40, exp_st());
        xfer(7'h41, 1'b1, 8'hff, d);
        `CHECK(d, 8'h00)
        xfer(7'h40, 1'b1, 8'h00, d);
        `CHECK(d, 8'h00)
        rd(7'h40, exp_st());
        rd(7'h27, 8'h00);
        rd(7'h4a, 8'h00);
        sys_rst = 1;
        tick(4);
        sys_rst = 0;
        exp_cal = 0;
        exp_fail = 0;
        tick(8);
        rd(7'h40, exp_st());
        test_done();
    end
endmodule : transceiver_status_readout_tb

`default_nettype wire
